// ### ftm_pkg.sv
/*
 * Shared constants and types for the flexible TDM output slot mapper.
 * Assumes a single 50 MHz bus clock and a 32-bit AHB-Lite register bus.
 */
package ftm_pkg;

    // Geometry of the slot map and the stream it drives.
    localparam int NUM_SLOTS = 64;
    localparam int SLOTS_PER_PIN = 32;
    localparam int NUM_PINS = 2;
    localparam int NUM_CHANNELS = 16;
    localparam int BITS_PER_SLOT = 8;

    // Register indices; the byte address of each register is four times its index.
    localparam logic [15:0] MAP_FIRST_INDEX = 16'hF380;
    localparam logic [15:0] MAP_LAST_INDEX = 16'hF3BF;
    localparam logic [15:0] CTRL_INDEX = 16'hF3C0;
    localparam logic [15:0] STATUS_INDEX = 16'hF3C1;

    // Reset values.
    localparam logic [15:0] SLOT_MAP_RESET = 16'h0000;
    localparam logic [1:0] PORT_HIZ_RESET = 2'h0;

    // AHB transfer type whose upper bit marks a real transfer.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Layout of one slot map register, bit 15 down to bit 0.
    typedef struct packed {
        logic [7:0] reserved;
        logic enable;
        logic reverse;
        logic group;
        logic [2:0] channel;
        logic [1:0] byte_sel;
    } ftm_slot_map_t;

    // What the mapper hands a serializer at each slot boundary.
    typedef struct packed {
        logic enable;
        logic [7:0] data;
    } ftm_slot_load_t;

    // One output pin: level and output enable (high while driven).
    typedef struct packed {
        logic data;
        logic oe;
    } ftm_pin_t;

    // Decoded target of a bus transfer.
    typedef enum logic [1:0] {
        FTM_ACC_NONE = 2'b00,
        FTM_ACC_MAP = 2'b01,
        FTM_ACC_CTRL = 2'b11,
        FTM_ACC_STATUS = 2'b10
    } ftm_access_t;

    // Serializer states.
    typedef enum logic {
        FTM_IDLE = 1'b0,
        FTM_SEND = 1'b1
    } ftm_ser_state_t;

endpackage

// ### ftm_rx_model.sv
/* Downstream TDM receiver: records the first 256 bits of each frame on both pins.
   Assumes the same hclk and tick strobes that drive the mapper. */
`timescale 1ns/1ps
module ftm_rx_model (
    input wire logic hclk,
    input wire logic frame_start,
    input wire logic bit_tick,
    input wire ftm_pkg::ftm_pin_t pin_two,
    input wire ftm_pkg::ftm_pin_t pin_three
);
    import ftm_pkg::*;
    ftm_pin_t rx_two [256];
    ftm_pin_t rx_three [256];
    int k = 256;
    // Each bit is taken at the tick that launches the next, after a full bit period.
    always @(posedge hclk) begin
        if (bit_tick && frame_start) begin
            k = 0;
        end else if (bit_tick && k < 256) begin
            rx_two[k] = pin_two;
            rx_three[k] = pin_three;
            k++;
        end
    end
endmodule

// ### ftm_slot_mapper.sv
/*
 * Flexible TDM output slot mapper: 64 slot map registers on AHB-Lite and two pin serializers.
 * Assumes channel words and serial timing strobes arrive on hclk from neighbouring logic.
 */
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps

// What this block does
// - Sixty-four slot map registers at consecutive indices F380 to F3BF.
// - Slots 0 to 31 go to pin two, 32 to 63 to pin three.
// - Each slot carries at most one byte of its selected channel.
// - Disabled slot with port port_hiz_when_idle set leaves the pin high impedance.
// - Disabled slot with port port_hiz_when_idle clear drives the pin low.
// - Enabled slot drives the selected byte of the selected channel.
// - Reverse bit sends the byte LSB first, else MSB first.
// - Group bit picks channels 0 to 7 or 8 to 15.
// - Three-bit position picks the channel within the group.
// - All slot map registers reset to zero.
// - Byte field 00 picks bits 31:24 down to 11 picking bits 7:0.
module ftm_slot_mapper (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [ftm_pkg::NUM_CHANNELS-1:0][31:0] channel_word,
    input wire logic frame_start,
    input wire logic bit_tick,
    output ftm_pkg::ftm_pin_t serial_data_out_pin_two,
    output ftm_pkg::ftm_pin_t serial_data_out_pin_three
);
    import ftm_pkg::*;

    localparam int SW = $clog2(SLOTS_PER_PIN);

    // Register storage and bus tracking.
    ftm_slot_map_t map_reg [NUM_SLOTS];
    ftm_slot_map_t map_next [NUM_SLOTS];
    logic [1:0] hiz_reg, hiz_next;
    logic wr_pend_reg, wr_pend_next;
    ftm_access_t wr_kind_reg, wr_kind_next;
    logic [5:0] wr_slot_reg, wr_slot_next;
    logic [31:0] rdata_reg, rdata_next;

    // Address phase decode.
    logic addr_phase;
    ftm_access_t acc_kind;
    logic [5:0] acc_slot;

    // Serializer hookup.
    logic [SW-1:0] ser_slot_next [NUM_PINS];
    logic [SW-1:0] ser_slot_now [NUM_PINS];
    logic ser_active [NUM_PINS];
    ftm_slot_load_t ser_load [NUM_PINS];
    ftm_pin_t ser_pin [NUM_PINS];
    logic [31:0] status_word;

    // The slave never inserts wait states and never reports an error.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
    assign addr_phase = hsel && htrans[1] && hready;

    // Decode the word index; the map block sits on a 64-word boundary.
    always_comb begin
        acc_kind = FTM_ACC_NONE;
        acc_slot = haddr[7:2];
        if (haddr[31:8] == {14'h0000, MAP_FIRST_INDEX[15:6]}) begin
            acc_kind = FTM_ACC_MAP;
        end else if (haddr[31:2] == {14'h0000, CTRL_INDEX}) begin
            acc_kind = FTM_ACC_CTRL;
        end else if (haddr[31:2] == {14'h0000, STATUS_INDEX}) begin
            acc_kind = FTM_ACC_STATUS;
        end
    end

    // Status view: each pin's active flag and current slot.
    assign status_word = {16'h0000,
                          ser_active[1], 2'b00, ser_slot_now[1],
                          ser_active[0], 2'b00, ser_slot_now[0]};

    // Bus next state: writes land in the data phase, reads are fetched in the address phase.
    // A read right behind a write to the same word sees the new data through the forward path.
    always_comb begin
        map_next = map_reg;
        hiz_next = hiz_reg;
        wr_pend_next = 1'b0;
        wr_kind_next = wr_kind_reg;
        wr_slot_next = wr_slot_reg;
        rdata_next = rdata_reg;
        if (wr_pend_reg) begin
            if (wr_kind_reg == FTM_ACC_MAP) begin
                map_next[wr_slot_reg] = ftm_slot_map_t'(hwdata[15:0]);
            end else if (wr_kind_reg == FTM_ACC_CTRL) begin
                hiz_next = hwdata[1:0];
            end
        end
        if (addr_phase) begin
            if (hwrite) begin
                wr_pend_next = (acc_kind == FTM_ACC_MAP) || (acc_kind == FTM_ACC_CTRL);
                wr_kind_next = acc_kind;
                wr_slot_next = acc_slot;
            end else begin
                case (acc_kind)
                    FTM_ACC_MAP: rdata_next = {16'h0000, 16'(map_next[acc_slot])};
                    FTM_ACC_CTRL: rdata_next = {30'h0, hiz_next};
                    FTM_ACC_STATUS: rdata_next = status_word;
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus and register flip-flops; every slot map clears at reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                map_reg[i] <= ftm_slot_map_t'(SLOT_MAP_RESET);
            end
            hiz_reg <= PORT_HIZ_RESET;
            wr_pend_reg <= 1'b0;
            wr_kind_reg <= FTM_ACC_NONE;
            wr_slot_reg <= 6'h00;
            rdata_reg <= 32'h0000_0000;
        end else begin
            map_reg <= map_next;
            hiz_reg <= hiz_next;
            wr_pend_reg <= wr_pend_next;
            wr_kind_reg <= wr_kind_next;
            wr_slot_reg <= wr_slot_next;
            rdata_reg <= rdata_next;
        end
    end

    // One serializer per pin; pin 0 owns slots 0..31, pin 1 owns slots 32..63.
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        ftm_slot_map_t cfg;
        logic [31:0] word;
        logic [7:0] raw;

        // Look up the map of the slot about to start and form its byte.
        always_comb begin
            cfg = map_reg[{1'(p), ser_slot_next[p]}];
            word = channel_word[{cfg.group, cfg.channel}];
            case (cfg.byte_sel)
                2'h0: raw = word[31:24];
                2'h1: raw = word[23:16];
                2'h2: raw = word[15:8];
                default: raw = word[7:0];
            endcase
            ser_load[p].enable = cfg.enable;
            if (cfg.reverse) begin
                ser_load[p].data = {<<{raw}};
            end else begin
                ser_load[p].data = raw;
            end
        end

        ftm_slot_serializer #(
            .SLOTS(SLOTS_PER_PIN)
        ) u_ser (
            .hclk(hclk),
            .hresetn(hresetn),
            .frame_start(frame_start),
            .bit_tick(bit_tick),
            .port_hiz_when_idle(hiz_reg[p]),
            .slot_load(ser_load[p]),
            .slot_next(ser_slot_next[p]),
            .slot_active(ser_active[p]),
            .slot_now(ser_slot_now[p]),
            .pin(ser_pin[p])
        );
    end

    // Pin two carries the lower slots, pin three the upper ones.
    assign serial_data_out_pin_two = ser_pin[0];
    assign serial_data_out_pin_three = ser_pin[1];

    // The transfer size is not checked: every access is treated as a whole word.
    logic unused_size;
    assign unused_size = ^hsize;

endmodule

// ### ftm_slot_mapper_checker.sv
/* Concurrent checks on the slot mapper's bus and pin ports.
   Bound to every ftm_slot_mapper; it sees nothing but that module's ports. */
`timescale 1ns/1ps
module ftm_slot_mapper_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic frame_start,
    input wire logic bit_tick,
    input wire ftm_pkg::ftm_pin_t serial_data_out_pin_two,
    input wire ftm_pkg::ftm_pin_t serial_data_out_pin_three
);
    logic [8:0] tick_reg;
    logic [8:0] tick_next;
    logic rd_off;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A read below the slot maps or above the status word hits nothing.
    assign rd_off = hsel && htrans[1] && hready && !hwrite && (haddr < 32'h0003CE00 || haddr > 32'h0003CF07);
    // Ticks since frame start; it saturates so a long idle never wraps into a frame.
    always_comb begin
        tick_next = tick_reg;
        if (bit_tick && frame_start) begin
            tick_next = 9'h001;
        end else if (bit_tick && tick_reg < 9'h12C) begin
            tick_next = tick_reg + 9'h001;
        end
    end
    // Registered count, parked past the frame while in reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_reg <= 9'h12C;
        end else begin
            tick_reg <= tick_next;
        end
    end
    chk_ready_const: assert property (hreadyout) else $error("wait state seen");
    chk_resp_okay: assert property (!hresp) else $error("error response seen");
    chk_unmapped_zero: assert property (rd_off |=> hrdata == 32'h00000000) else $error("unmapped read");
    chk_upper_zero: assert property (hrdata[31:16] == 16'h0000) else $error("upper half set");
    chk_two_hold: assert property (!bit_tick |=> $stable(serial_data_out_pin_two.data)) else $error("pin two moved");
    chk_three_hold: assert property (!bit_tick |=> $stable(serial_data_out_pin_three.data)) else $error("pin three moved");
    chk_two_idle: assert property (tick_reg > 9'h100 |-> !serial_data_out_pin_two.data) else $error("pin two idle");
    chk_three_idle: assert property (tick_reg > 9'h100 |-> !serial_data_out_pin_three.data) else $error("pin three idle");
endmodule
bind ftm_slot_mapper ftm_slot_mapper_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .frame_start, .bit_tick, .serial_data_out_pin_two, .serial_data_out_pin_three);

// ### ftm_slot_mapper_tb_top.sv
/* Self-checking bench: AHB-Lite master, random slot maps and channel words, bit model.
   Assumes zero-wait slave; ticks every fourth clock. */
`timescale 1ns/1ps
module ftm_slot_mapper_tb_top;
    import ftm_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [NUM_CHANNELS-1:0][31:0] channel_word = '0;
    logic frame_start = 1'b0;
    logic bit_tick = 1'b0;
    ftm_pin_t pin_two;
    ftm_pin_t pin_three;
    logic [15:0] map_m [NUM_SLOTS];
    logic [1:0] hiz_m;
    logic [31:0] seed = 32'h1;
    logic [31:0] rd;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    always #10 hclk = ~hclk;
    ftm_slot_mapper DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .channel_word, .frame_start, .bit_tick,
        .serial_data_out_pin_two(pin_two), .serial_data_out_pin_three(pin_three));
    ftm_rx_model RX (.hclk, .frame_start, .bit_tick, .pin_two, .pin_three);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected level of bit k of a pin; a tristated slot is judged on its enable only.
    function automatic ftm_pin_t exp_bit(int p, int k);
        logic [15:0] m;
        logic [7:0] y;
        m = map_m[p * 32 + k / 8];
        y = 8'(channel_word[m[5:2]] >> (8 * (3 - m[1:0])));
        if (m[7]) return {m[6] ? y[k % 8] : y[7 - k % 8], 1'b1};
        return {1'b0, ~hiz_m[p]};
    endfunction
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input ftm_pin_t got, input ftm_pin_t exp, input int k);
        compares++;
        if (exp.oe ? got !== exp : got.oe !== 1'b0) begin
            n_errors++;
            $display("[ERR] %0t bit %0d got %b want %b", $time, k, got, exp);
        end
    endtask
    // One single transfer; the address phase is held until hready is seen high.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic run_frame(input logic [1:0] hz, input string name);
        logic [31:0] v;
        hiz_m = hz;
        bus(1'b1, 32'h0003CF00, {30'h0, hz});
        // Read straight behind the write: the new port_hiz_when_idle bits must already show.
        bus(1'b0, 32'h0003CF00, 32'h0);
        chk_reg(rd, {30'h0, hz});
        for (int i = 0; i < NUM_SLOTS; i++) begin
            v = xs();
            map_m[i] = v[15:0];
            bus(1'b1, 32'(32'h0003CE00 + 4 * i), v);
        end
        for (int i = 0; i < NUM_SLOTS; i++) begin
            bus(1'b0, 32'(32'h0003CE00 + 4 * i), 32'h0);
            chk_reg(rd, {16'h0, map_m[i]});
        end
        for (int c = 0; c < NUM_CHANNELS; c++) channel_word[c] <= xs();
        for (int i = 0; i < 257; i++) begin
            frame_start <= (i == 0);
            bit_tick <= 1'b1;
            @(posedge hclk);
            frame_start <= 1'b0;
            bit_tick <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        // After the last slot both pins rest on slot 31 with the walk stopped.
        bus(1'b0, 32'h0003CF04, 32'h0);
        chk_reg(rd, 32'h00001F1F);
        for (int k = 0; k < 256; k++) begin
            chk_pin(RX.rx_two[k], exp_bit(0, k), k);
            chk_pin(RX.rx_three[k], exp_bit(1, k), k);
        end
        $display("test %s done", name);
    endtask
    // The ceiling is about five times the expected run length.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < NUM_SLOTS; i++) begin
            bus(1'b0, 32'(32'h0003CE00 + 4 * i), 32'h0);
            chk_reg(rd, 32'h0);
        end
        bus(1'b0, 32'h00000100, 32'h0);
        chk_reg(rd, 32'h0);
        // Before any frame both walks sit idle on slot 0.
        bus(1'b0, 32'h0003CF04, 32'h0);
        chk_reg(rd, 32'h0);
        $display("test reset_values done");
        run_frame(2'h0, "drive_low");
        run_frame(2'h1, "hiz_two");
        run_frame(2'h2, "hiz_three");
        wrap_up();
    end
endmodule

// ### ftm_slot_serializer.sv
/*
 * Serializer for one TDM output pin: walks the pin's slots in order and shifts each byte out MSB first.
 * Assumes frame_start and bit_tick are one-cycle strobes on hclk from the serial port timing logic.
 */
`timescale 1ns/1ps
module ftm_slot_serializer #(
    parameter int SLOTS = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic frame_start,
    input wire logic bit_tick,
    input wire logic port_hiz_when_idle,
    input wire ftm_pkg::ftm_slot_load_t slot_load,
    output logic [$clog2(SLOTS)-1:0] slot_next,
    output logic slot_active,
    output logic [$clog2(SLOTS)-1:0] slot_now,
    output ftm_pkg::ftm_pin_t pin
);
    import ftm_pkg::*;

    localparam int SW = $clog2(SLOTS);
    localparam logic [SW-1:0] LAST_SLOT = SW'(SLOTS - 1);
    localparam logic [2:0] LAST_BIT = 3'(BITS_PER_SLOT - 1);

    ftm_ser_state_t state_reg, state_next;
    logic [SW-1:0] slot_reg, slot_nx;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic en_reg, en_next;
    ftm_pin_t pin_reg, pin_next;

    // Slot whose byte the mapper must present: slot 0 at frame start, else the following one.
    assign slot_next = frame_start ? '0 : SW'(slot_reg + 1'b1);

    // Slot walk: eight bit ticks per slot, ascending order, idle after the last slot.
    always_comb begin
        state_next = state_reg;
        slot_nx = slot_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        en_next = en_reg;
        if (bit_tick) begin
            if (frame_start) begin
                state_next = FTM_SEND;
                slot_nx = '0;
                bit_next = '0;
                shift_next = slot_load.data;
                en_next = slot_load.enable;
            end else if (state_reg == FTM_SEND) begin
                if (bit_reg == LAST_BIT) begin
                    bit_next = '0;
                    if (slot_reg == LAST_SLOT) begin
                        state_next = FTM_IDLE;
                        en_next = 1'b0;
                    end else begin
                        slot_nx = slot_next;
                        shift_next = slot_load.data;
                        en_next = slot_load.enable;
                    end
                end else begin
                    bit_next = bit_reg + 3'h1;
                    shift_next = {shift_reg[6:0], 1'b0};
                end
            end
        end
    end

    // Pin level: data when enabled, else low or released by the port's port_hiz_when_idle choice.
    always_comb begin
        if (state_next == FTM_SEND && en_next) begin
            pin_next.data = shift_next[7];
            pin_next.oe = 1'b1;
        end else begin
            pin_next.data = 1'b0;
            pin_next.oe = ~port_hiz_when_idle;
        end
    end

    // State registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= FTM_IDLE;
            slot_reg <= '0;
            bit_reg <= '0;
            shift_reg <= 8'h00;
            en_reg <= 1'b0;
            pin_reg <= '0;
        end else begin
            state_reg <= state_next;
            slot_reg <= slot_nx;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            en_reg <= en_next;
            pin_reg <= pin_next;
        end
    end

    assign pin = pin_reg;
    assign slot_active = (state_reg == FTM_SEND);
    assign slot_now = slot_reg;

endmodule
